// ==== common/ccg_regs.svh ====
// constants of the configuration clear gesture sequencer
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH
`define CCG_CLK_HZ 50000000
`define CCG_START_WIN_S 120
`define CCG_STEP_S 3
`define CCG_WINDOW_S 30
`define CCG_COMMIT_S 120
`define CCG_RES_MIN_S 1
`define CCG_RES_MAX_S 3
`define CCG_MIN_QUAL 3
`define CCG_NUM_STEPS 5
`define CCG_FLASH_MS 200
`define CCG_CHASE_MS 100
`define CCG_IRQ_CLEARED 0
`define CCG_IRQ_CANCEL 1
`define CCG_IRQ_RESLOCK 2
`define CCG_IRQ_FBMON 3
`define CCG_ADDR_STAT 2'h0
`define CCG_ADDR_MASK 2'h1
`define CCG_ADDR_CFG 2'h2
`endif

// ==== common/ccg_pkg.sv ====
// types of the configuration clear gesture sequencer
`default_nettype none
package ccg_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_BLOCK = 9'h002,
    ST_WREL = 9'h004,
    ST_CLEAR = 9'h008,
    ST_WBLK = 9'h010,
    ST_DONE = 9'h020,
    ST_LOCK = 9'h040,
    ST_WPOS = 9'h080,
    ST_SPARE = 9'h100
  } ccg_state_e;
  typedef struct packed {
    logic blocked;
    logic center;
    logic outer;
  } ccg_beam_s;
  typedef struct packed {
    logic single_plug;
    logic ext_cabled;
    logic ext_upstream;
  } ccg_plug_s;
  typedef enum logic [2:0] {
    ROLE_SINGLE = 3'h1,
    ROLE_HOST = 3'h2,
    ROLE_GUEST = 3'h4
  } ccg_role_e;
endpackage
`default_nettype wire

// ==== hw/ccg_seq.sv ====
// configuration clear gesture sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ccg_regs.svh"
module ccg_seq #(
  parameter int unsigned CLK_HZ = `CCG_CLK_HZ,
  parameter int unsigned SEC_CYC = CLK_HZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ccg_pkg::ccg_beam_s beam,
  input wire logic [4:0] quality,
  input wire ccg_pkg::ccg_plug_s plug,
  input wire logic fb_wired,
  input wire logic first_switch,
  input wire logic reset_button,
  input wire logic power_off,
  input wire logic nv_clear_pend,
  input wire logic nv_restart_lock,
  input wire logic nv_fb_mon,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  output logic comm_indicator,
  output logic [4:0] align_blue,
  output logic restart_lock_led,
  output logic fb_mon_led,
  output logic restart_lock,
  output logic contactor_feedback_monitor,
  output logic clear_pend,
  output logic nv_write,
  output ccg_pkg::ccg_role_e role,
  output logic cascade_err
);
  localparam int unsigned FLASH_CYC = (SEC_CYC / 1000) * `CCG_FLASH_MS;
  localparam int unsigned CHASE_CYC = (SEC_CYC / 1000) * `CCG_CHASE_MS;

  ccg_pkg::ccg_state_e state;
  logic [31:0] pre;
  logic sec_tick;
  logic [7:0] up_sec;
  logic [7:0] st_sec;
  logic [2:0] step;
  logic want_center;
  logic start_open;
  logic qual_ok;
  logic [2:0] flash_req;
  logic [2:0] flash_cnt;
  logic [31:0] flash_tmr;
  logic flash_on;
  logic blue_flash;
  logic chase_on;
  logic chase_out;
  logic [2:0] chase_pos;
  logic [31:0] chase_tmr;
  logic [7:0] btn_sec;
  logic btn_q;
  logic ev_cleared, ev_cancel, ev_res, ev_fb;
  logic [3:0] stat, mask, ev;
  logic boot_done;
  logic idle_armed;

  // count lit quality levels
  function automatic logic [2:0] pop5(input logic [4:0] v);
    pop5 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
  endfunction

  assign qual_ok = pop5(quality) >= 3'(`CCG_MIN_QUAL);
  assign start_open = up_sec < 8'(`CCG_START_WIN_S);

  // one-second enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre <= 32'h0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (pre == SEC_CYC - 1);
      pre <= (pre == SEC_CYC - 1) ? 32'h0 : pre + 32'h1;
    end
  end

  // seconds since power-up, saturating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      up_sec <= 8'h0;
    end else if (sec_tick && up_sec != 8'hff) begin
      up_sec <= up_sec + 8'h1;
    end
  end

  // role from plug only, nothing stored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      role <= ccg_pkg::ROLE_SINGLE;
      cascade_err <= 1'b0;
    end else begin
      if (plug.single_plug) begin
        role <= plug.ext_upstream ? ccg_pkg::ROLE_GUEST : ccg_pkg::ROLE_SINGLE;
      end else begin
        role <= plug.ext_upstream ? ccg_pkg::ROLE_GUEST : ccg_pkg::ROLE_HOST;
      end
      // cascade plug with nothing cabled
      cascade_err <= !plug.single_plug && !plug.ext_cabled;
    end
  end

  // gesture sequence
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ccg_pkg::ST_IDLE;
      st_sec <= 8'h0;
      step <= 3'h0;
      want_center <= 1'b1;
      flash_req <= 3'h0;
      blue_flash <= 1'b0;
      chase_on <= 1'b0;
      chase_out <= 1'b0;
      ev_cleared <= 1'b0;
      ev_cancel <= 1'b0;
      clear_pend <= 1'b0;
      idle_armed <= 1'b0;
    end else begin
      flash_req <= 3'h0;
      ev_cleared <= 1'b0;
      ev_cancel <= 1'b0;
      st_sec <= sec_tick ? st_sec + 8'h1 : st_sec;
      case (state)
        ccg_pkg::ST_IDLE: begin
          st_sec <= 8'h0;
          if (!beam.blocked) begin
            idle_armed <= 1'b1; // a new first step needs a clear field
          end
          if (!start_open) begin
            state <= ccg_pkg::ST_LOCK;
          end else if (beam.blocked && qual_ok && idle_armed) begin
            state <= ccg_pkg::ST_BLOCK;
            step <= 3'h0;
            idle_armed <= 1'b0;
          end
        end
        ccg_pkg::ST_BLOCK: begin
          if (!beam.blocked || !qual_ok) begin
            state <= (step == 3'h0) ? ccg_pkg::ST_IDLE : ccg_pkg::ST_WPOS;
            st_sec <= 8'h0;
          end else if (step != 3'h0 && (beam.center != want_center)) begin
            state <= ccg_pkg::ST_WPOS;
          end else if (st_sec >= 8'(`CCG_STEP_S)) begin
            flash_req <= 3'h1;
            state <= ccg_pkg::ST_WREL;
            st_sec <= 8'h0;
          end
        end
        ccg_pkg::ST_WREL: begin
          if (!beam.blocked) begin
            state <= ccg_pkg::ST_CLEAR;
            st_sec <= 8'h0;
            chase_on <= (step != 3'(`CCG_NUM_STEPS - 1));
            chase_out <= (step == 3'h0) ? 1'b0 : want_center; // first hint points inward to center
            want_center <= (step == 3'h0) ? 1'b1 : !want_center;
          end else if (st_sec >= 8'(`CCG_WINDOW_S)) begin
            state <= ccg_pkg::ST_WPOS;
          end
        end
        ccg_pkg::ST_CLEAR: begin
          if (beam.blocked) begin
            state <= ccg_pkg::ST_WPOS;
          end else if (st_sec >= 8'(`CCG_STEP_S)) begin
            st_sec <= 8'h0;
            if (step == 3'(`CCG_NUM_STEPS - 1)) begin
              flash_req <= 3'h3;
              blue_flash <= 1'b1;
              chase_on <= 1'b0;
              ev_cleared <= 1'b1;
              state <= ccg_pkg::ST_DONE;
            end else begin
              flash_req <= 3'h1;
              state <= ccg_pkg::ST_WBLK;
            end
          end
        end
        ccg_pkg::ST_WBLK: begin
          if (beam.blocked) begin
            step <= step + 3'h1;
            st_sec <= 8'h0;
            state <= ccg_pkg::ST_BLOCK;
            chase_on <= 1'b0;
          end else if (st_sec >= 8'(`CCG_WINDOW_S)) begin
            state <= ccg_pkg::ST_WPOS;
          end
        end
        ccg_pkg::ST_DONE: begin
          if (power_off) begin
            clear_pend <= 1'b1;
          end
          if (st_sec >= 8'(`CCG_COMMIT_S)) begin
            state <= ccg_pkg::ST_LOCK;
            blue_flash <= 1'b0;
          end
        end
        ccg_pkg::ST_WPOS: begin
          flash_req <= 3'h2;
          ev_cancel <= 1'b1;
          chase_on <= 1'b0;
          want_center <= 1'b1;
          idle_armed <= 1'b0;
          state <= ccg_pkg::ST_IDLE;
        end
        ccg_pkg::ST_LOCK: begin
          st_sec <= 8'h0;
        end
        default: begin
          state <= ccg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // comm indicator flash train
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_cnt <= 3'h0;
      flash_tmr <= 32'h0;
      flash_on <= 1'b0;
    end else if (flash_req != 3'h0) begin
      flash_cnt <= flash_req;
      flash_tmr <= 32'h0;
      flash_on <= 1'b1;
    end else if (flash_cnt != 3'h0) begin
      if (flash_tmr == FLASH_CYC - 1) begin
        flash_tmr <= 32'h0;
        flash_on <= !flash_on; // off phase ends only while flashes remain
        flash_cnt <= flash_on ? flash_cnt - 3'h1 : flash_cnt;
      end else begin
        flash_tmr <= flash_tmr + 32'h1;
      end
    end
  end

  // alignment chaser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chase_pos <= 3'h0;
      chase_tmr <= 32'h0;
    end else if (chase_tmr == CHASE_CYC - 1) begin
      chase_tmr <= 32'h0;
      chase_pos <= (chase_pos == 3'h4) ? 3'h0 : chase_pos + 3'h1;
    end else begin
      chase_tmr <= chase_tmr + 32'h1;
    end
  end

  // blue lights: chaser, success flash or quality bar
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      align_blue <= 5'h00;
      comm_indicator <= 1'b0;
    end else begin
      comm_indicator <= flash_on;
      if (chase_on) begin
        align_blue <= chase_out ? (5'h01 << chase_pos) : (5'h10 >> chase_pos);
      end else if (blue_flash) begin
        align_blue <= flash_on ? 5'h1f : 5'h00;
      end else begin
        align_blue <= quality;
      end
    end
  end

  // boot load of stored functions and button timing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_done <= 1'b0;
      restart_lock <= 1'b0;
      contactor_feedback_monitor <= 1'b0;
      btn_sec <= 8'h0;
      btn_q <= 1'b0;
      ev_res <= 1'b0;
      ev_fb <= 1'b0;
      nv_write <= 1'b0;
    end else begin
      ev_res <= 1'b0;
      ev_fb <= 1'b0;
      nv_write <= 1'b0;
      btn_q <= reset_button;
      if (!boot_done) begin
        boot_done <= 1'b1;
        restart_lock <= nv_clear_pend ? 1'b0 : nv_restart_lock;
        contactor_feedback_monitor <= nv_clear_pend ? 1'b0 : nv_fb_mon;
        nv_write <= nv_clear_pend;
      end else begin
        if (fb_wired && first_switch && !contactor_feedback_monitor) begin
          contactor_feedback_monitor <= 1'b1;
          ev_fb <= 1'b1;
          nv_write <= 1'b1;
        end
        if (reset_button) begin
          btn_sec <= (sec_tick && btn_sec != 8'hff) ? btn_sec + 8'h1 : btn_sec;
        end else begin
          btn_sec <= 8'h0;
        end
        if (btn_q && !reset_button && btn_sec >= 8'(`CCG_RES_MIN_S)
            && btn_sec < 8'(`CCG_RES_MAX_S) && !restart_lock) begin
          restart_lock <= 1'b1;
          ev_res <= 1'b1;
          nv_write <= 1'b1;
        end
      end
    end
  end

  assign fb_mon_led = contactor_feedback_monitor;
  assign restart_lock_led = restart_lock && (pre < SEC_CYC / 2);

  // sticky status, write one clears, set wins
  assign ev = {ev_fb, ev_res, ev_cancel, ev_cleared};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat <= 4'h0;
      mask <= 4'h0;
    end else begin
      if (wr && addr == `CCG_ADDR_MASK) begin
        mask <= wdata[3:0];
      end
      if (wr && addr == `CCG_ADDR_STAT) begin
        stat <= (stat & ~wdata[3:0]) | ev;
      end else begin
        stat <= stat | ev;
      end
    end
  end
  assign irq = |(stat & mask);

  // register read data, one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `CCG_ADDR_STAT: rdata <= {4'h0, stat};
        `CCG_ADDR_MASK: rdata <= {4'h0, mask};
        `CCG_ADDR_CFG: rdata <= {3'h0, clear_pend, step, restart_lock};
        default: rdata <= {contactor_feedback_monitor, role, 1'b0, state == ccg_pkg::ST_LOCK, 2'h0};
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  a_start_win: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ccg_pkg::ST_IDLE && !start_open) |=> state == ccg_pkg::ST_LOCK) else $error("late start");
  a_quality_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ccg_pkg::ST_IDLE && !qual_ok) |=> state != ccg_pkg::ST_BLOCK) else $error("low quality start");
  a_block_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ccg_pkg::ST_BLOCK ##1 state == ccg_pkg::ST_WREL)
    |-> flash_req == 3'h1) else $error("block ack missing");
  a_release_win: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ccg_pkg::ST_WREL && st_sec > 8'(`CCG_WINDOW_S)) |-> 1'b0) else $error("release window");
  a_cancel_two: assert property (@(posedge clk) disable iff (!rst_b)
    state == ccg_pkg::ST_WPOS |=> flash_req == 3'h2 && state == ccg_pkg::ST_IDLE) else $error("cancel flash");
  a_success_blue: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(ev_cleared) |-> blue_flash && state == ccg_pkg::ST_DONE) else $error("success flash");
  a_commit_power: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(clear_pend) |-> $past(state) == ccg_pkg::ST_DONE && $past(power_off))
    else $error("commit outside window");
  a_step_bound: assert property (@(posedge clk) disable iff (!rst_b)
    step < 3'(`CCG_NUM_STEPS)) else $error("step range");
endmodule
`default_nettype wire

// ==== dv/ccg_operator.sv ====
// operator model that blocks and clears the beam field
`timescale 1ns/10ps
`default_nettype none
module ccg_operator (
  input wire logic clk,
  output var ccg_pkg::ccg_beam_s beam
);
  // field starts clear
  initial begin
    beam = '0;
  end

  // hold one field state for a number of cycles
  task automatic step(input logic blk, input logic ctr, input int unsigned cyc);
    @(posedge clk);
    if (blk) begin
      beam <= {1'b1, ctr, ~ctr};
    end else begin
      // released position lines carry no meaning, so they toggle
      beam <= {1'b0, ~beam.center, ~beam.outer};
    end
    repeat (cyc) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_ccg_seq.sv ====
// self-checking bench of the configuration clear gesture sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ccg_regs.svh"
module tb_ccg_seq;
  localparam int unsigned SEC = 1000;
  localparam int unsigned STEP = 3300;
  localparam logic [4:0] POS = 5'b01011;
  localparam logic [2:0] PLUGS [3] = '{3'b100, 3'b010, 3'b011};
  localparam logic [2:0] ROLES [3] = '{ccg_pkg::ROLE_SINGLE, ccg_pkg::ROLE_HOST, ccg_pkg::ROLE_GUEST};
  logic clk, rst_b, fb_wired, first_switch, reset_button, power_off;
  logic nv_clear_pend, nv_restart_lock, nv_fb_mon, wr, rd, irq, comm_indicator;
  logic restart_lock_led, fb_mon_led, restart_lock, contactor_feedback_monitor;
  logic clear_pend, nv_write, cascade_err, comm_q, blue_q, nvw_q, rll_q;
  logic [4:0] quality, align_blue;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  ccg_pkg::ccg_plug_s plug;
  ccg_pkg::ccg_beam_s beam;
  ccg_pkg::ccg_role_e role;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_flash = 0;
  int n_blue = 0;
  int n_nvw = 0;
  int n_rll = 0;

  ccg_seq #(.SEC_CYC(SEC)) u_dut (.clk(clk), .rst_b(rst_b), .beam(beam), .quality(quality),
    .plug(plug), .fb_wired(fb_wired), .first_switch(first_switch), .reset_button(reset_button),
    .power_off(power_off), .nv_clear_pend(nv_clear_pend), .nv_restart_lock(nv_restart_lock),
    .nv_fb_mon(nv_fb_mon), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .comm_indicator(comm_indicator), .align_blue(align_blue), .restart_lock_led(restart_lock_led),
    .fb_mon_led(fb_mon_led), .restart_lock(restart_lock),
    .contactor_feedback_monitor(contactor_feedback_monitor), .clear_pend(clear_pend),
    .nv_write(nv_write), .role(role), .cascade_err(cascade_err));

  ccg_operator u_op (.clk(clk), .beam(beam));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // count white flashes, full blue flashes and store requests
  always @(posedge clk) begin
    comm_q <= comm_indicator;
    blue_q <= (align_blue === 5'h1f);
    nvw_q <= nv_write;
    rll_q <= restart_lock_led;
    if (restart_lock_led === 1'b1 && rll_q !== 1'b1) n_rll <= n_rll + 1;
    if (comm_indicator === 1'b1 && comm_q !== 1'b1) n_flash <= n_flash + 1;
    if (align_blue === 5'h1f && blue_q !== 1'b1) n_blue <= n_blue + 1;
    if (nv_write === 1'b1 && nvw_q !== 1'b1) n_nvw <= n_nvw + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // cut a hung run short
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    int f0;
    int b0;
    rst_b = 1'b0;
    quality = 5'h07;
    plug = 3'b100;
    fb_wired = 1'b0;
    first_switch = 1'b0;
    reset_button = 1'b0;
    power_off = 1'b0;
    nv_clear_pend = 1'b0;
    nv_restart_lock = 1'b0;
    nv_fb_mon = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk);
    chk({5'h0, role}, {5'h0, ccg_pkg::ROLE_SINGLE});
    chk({6'h0, irq, restart_lock}, 8'h00);
    rst_b <= 1'b1;
    rd_chk(`CCG_ADDR_STAT, 8'h00);
    wr_reg(`CCG_ADDR_MASK, 8'h0f);
    rd_chk(`CCG_ADDR_MASK, 8'h0f);
    // wired feedback input and a 2 s press of the reset button
    fb_wired <= 1'b1;
    first_switch <= 1'b1;
    reset_button <= 1'b1;
    repeat (2 * SEC) @(posedge clk);
    reset_button <= 1'b0;
    repeat (20) @(posedge clk);
    fb_wired <= 1'b0;
    first_switch <= 1'b0;
    chk({6'h0, restart_lock, contactor_feedback_monitor}, 8'h03);
    chk({7'h0, fb_mon_led}, 8'h01);
    repeat (SEC) @(posedge clk);
    chk(8'(n_rll != 0), 8'h01);
    rd_chk(`CCG_ADDR_STAT, 8'h0c);
    rd_chk(2'h3, 8'h90);
    chk({7'h0, irq}, 8'h01);
    wr_reg(`CCG_ADDR_MASK, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr_reg(`CCG_ADDR_MASK, 8'h0f);
    wr_reg(`CCG_ADDR_STAT, 8'h0c);
    rd_chk(`CCG_ADDR_STAT, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // poor alignment: a long block is ignored
    quality <= 5'h03;
    f0 = n_flash;
    u_op.step(1'b1, 1'b1, STEP);
    u_op.step(1'b0, 1'b0, SEC);
    chk(8'(n_flash - f0), 8'h00);
    // wrong second position cancels
    quality <= 5'h07;
    f0 = n_flash;
    u_op.step(1'b1, 1'b1, STEP);
    u_op.step(1'b0, 1'b0, STEP);
    u_op.step(1'b1, 1'b0, STEP);
    u_op.step(1'b0, 1'b0, 2 * SEC);
    chk(8'(n_flash - f0), 8'h04);
    rd_chk(`CCG_ADDR_STAT, 8'h02);
    wr_reg(`CCG_ADDR_STAT, 8'h02);
    // full clearing sequence
    f0 = n_flash;
    b0 = n_blue;
    for (int i = 0; i < 5; i++) begin
      u_op.step(1'b1, POS[i], STEP);
      u_op.step(1'b0, 1'b0, SEC + SEC / 2);
      if (i < 4) chk({7'h0, |align_blue}, 8'h01);
      repeat (2 * SEC) @(posedge clk);
    end
    repeat (2 * SEC) @(posedge clk);
    chk(8'(n_flash - f0), 8'h0c);
    chk(8'(n_blue - b0), 8'h03);
    rd_chk(`CCG_ADDR_STAT, 8'h01);
    power_off <= 1'b1;
    repeat (10) @(posedge clk);
    chk({7'h0, clear_pend}, 8'h01);
    // power-up with a committed clearing
    nv_clear_pend <= 1'b1;
    nv_restart_lock <= 1'b1;
    nv_fb_mon <= 1'b1;
    power_off <= 1'b0;
    f0 = n_nvw;
    do_reset();
    repeat (10) @(posedge clk);
    chk({6'h0, restart_lock, contactor_feedback_monitor}, 8'h00);
    chk(8'(n_nvw - f0), 8'h01);
    // role from the plug at each power-up
    nv_clear_pend <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      plug <= PLUGS[i];
      do_reset();
      repeat (4) @(posedge clk);
      chk({5'h0, role}, {5'h0, ROLES[i]});
      chk({7'h0, cascade_err}, 8'h00);
    end
    plug <= 3'b000;
    do_reset();
    repeat (4) @(posedge clk);
    chk({7'h0, cascade_err}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
